// ---- power_mode_fsm.v ----
// Controller power-mode state machine with Wishbone control registers
//
// Notes on behaviour
// - Powered down: no driving, no status frames; only key on leads to normal.
// - Normal mode: drivable and status frames go out on the link.
// - Key off in normal goes to low power if enabled, else powered down.
// - Sleep timer above zero and throttle neutral that many minutes enters sleep.
// - Sleep ignores throttle drive, keeps inputs monitored, status frames continue.
// - Sleep indicator pulses once every five seconds while sleeping.
// - Wake to normal by key off-then-on or throttle deflection, as selected.
// - Sleep goes low power on key off, six hours, throttle fault, flat, charging.
// - Low power ends in powered down on duration expiry or flat battery.
// - Low-power duration is programmable from 0 to 90 days.
// - Duration zero bypasses low power from normal: key off goes straight to powered down.
// - Key on in low power returns directly to normal mode.
//
// Design decisions made here: the Wishbone register port and the register addresses.
`include "power_mode_map.vh"
`default_nettype none
module power_mode_fsm #(
    parameter SEC_CYCLES  = `SEC_CYCLES,
    parameter DAY_S       = `DAY_S,
    parameter SLEEP_MAX_S = `SLEEP_MAX_S,
    parameter LP_STATUS_S = `LP_STATUS_S
) (
    // Clock and reset
    input  wire          sys_clk_i,
    input  wire          arst_n_i,
    // Wishbone slave
    input  wire          wb_cyc_i,
    input  wire          wb_stb_i,
    input  wire          wb_we_i,
    input  wire [7:0]    wb_adr_i,
    input  wire [3:0]    wb_sel_i,
    input  wire [31:0]   wb_dat_i,
    output reg  [31:0]   wb_dat_o,
    output reg           wb_ack_o,
    // Key, throttle and battery sensing
    input  wire          key_on_i,
    input  wire          throttle_neutral_i,
    input  wire          throttle_fault_i,
    input  wire          battery_flat_i,
    input  wire          battery_charging_i,
    // Mode outputs
    output reg  [1:0]    power_state_o,
    output reg           drive_enable_o,
    output reg           monitor_enable_o,
    output reg           status_frame_o,
    output reg           sleep_led_o
);
    localparam [1:0]  ST_DOWN   = `ST_DOWN;
    localparam [1:0]  ST_NORMAL = `ST_NORMAL;
    localparam [1:0]  ST_SLEEP  = `ST_SLEEP;
    localparam [1:0]  ST_LOWPWR = `ST_LOWPWR;
    localparam [6:0]  DAYS_MAX  = `LP_DAYS_MAX;
    localparam [22:0] DAY_S_W   = DAY_S[22:0];
    localparam [15:0] SLEEP_MAX = SLEEP_MAX_S[15:0];
    localparam [15:0] LPSTAT_LAST = LP_STATUS_S[15:0] - 16'h0001;
    localparam [2:0]  FLASH_LAST = `FLASH_PERIOD_S - 3'h1;
    localparam [15:0] MIN_S_W   = `MIN_S;

    // Seconds in a number of minutes
    function [15:0] mins_to_secs;
        input [7:0] m;
        begin
            mins_to_secs = {8'h00, m} * MIN_S_W;
        end
    endfunction

    // Seconds in a number of days
    function [22:0] days_to_secs;
        input [6:0] d;
        begin
            days_to_secs = {16'h0000, d} * DAY_S_W;
        end
    endfunction

    reg  [1:0]   state_reg;
    reg  [1:0]   state_next;
    reg          key_prev_reg;
    reg  [7:0]   sleep_min_reg;
    reg          wake_throttle_reg;
    reg  [6:0]   lp_days_reg;
    reg  [6:0]   days_wr;
    reg  [2:0]   flash_reg;
    wire         sec_tick;
    wire [15:0]  inact_cnt;
    wire [15:0]  sleep_cnt;
    wire [22:0]  lp_cnt;
    wire [15:0]  lpstat_cnt;
    wire         key_rise;
    wire         key_fall;
    wire         lp_enabled;
    wire         inact_done;
    wire         lp_done;
    wire         lpstat_due;
    wire         to_lowpwr;
    wire         wb_req;
    wire         wb_write;
    wire         state_chg;

    // Key edges from the previous sample
    assign key_rise   = key_on_i & ~key_prev_reg;
    assign key_fall   = ~key_on_i & key_prev_reg;

    // Key off in normal enters low power only with a non-zero duration
    assign lp_enabled = (lp_days_reg != 7'h00);

    // Inactivity expiry, disabled when the setting is zero
    assign inact_done = (sleep_min_reg != 8'h00) &&
                        (inact_cnt >= mins_to_secs(sleep_min_reg));

    // Low-power duration expiry
    assign lp_done    = (lp_cnt >= days_to_secs(lp_days_reg));

    // Sleep exit causes that lead to low power
    assign to_lowpwr  = key_fall || (sleep_cnt >= SLEEP_MAX) || throttle_fault_i ||
                        battery_flat_i || battery_charging_i;

    // Twelve-hour status point in low power
    assign lpstat_due = sec_tick && (lpstat_cnt >= LPSTAT_LAST);

    assign state_chg  = (state_next != state_reg);

    // One-second time base
    sec_tick_gen #(
        .CYCLES (SEC_CYCLES),
        .CW     (`SEC_CNT_W)
    ) u_tick (
        .sys_clk_i (sys_clk_i),
        .arst_n_i  (arst_n_i),
        .tick_o    (sec_tick)
    );

    // Continuous neutral time in normal mode
    sec_counter #(.W(16)) u_inact (
        .sys_clk_i (sys_clk_i),
        .arst_n_i  (arst_n_i),
        .clear_i   (state_reg != ST_NORMAL || !throttle_neutral_i),
        .tick_i    (sec_tick),
        .count_o   (inact_cnt)
    );

    // Time spent in sleep
    sec_counter #(.W(16)) u_sleep (
        .sys_clk_i (sys_clk_i),
        .arst_n_i  (arst_n_i),
        .clear_i   (state_reg != ST_SLEEP),
        .tick_i    (sec_tick),
        .count_o   (sleep_cnt)
    );

    // Time spent in low power
    sec_counter #(.W(23)) u_lp (
        .sys_clk_i (sys_clk_i),
        .arst_n_i  (arst_n_i),
        .clear_i   (state_reg != ST_LOWPWR),
        .tick_i    (sec_tick),
        .count_o   (lp_cnt)
    );

    // Spacing of status frames in low power
    sec_counter #(.W(16)) u_lpstat (
        .sys_clk_i (sys_clk_i),
        .arst_n_i  (arst_n_i),
        .clear_i   (state_reg != ST_LOWPWR || lpstat_due),
        .tick_i    (sec_tick),
        .count_o   (lpstat_cnt)
    );

    // Next power state
    always @*
    begin
        state_next = state_reg;
        case (state_reg)
            ST_DOWN:
            begin
                if (key_rise)
                    state_next = ST_NORMAL;
            end
            ST_NORMAL:
            begin
                if (key_fall)
                    state_next = lp_enabled ? ST_LOWPWR : ST_DOWN;
                else if (inact_done)
                    state_next = ST_SLEEP;
            end
            ST_SLEEP:
            begin
                if (to_lowpwr)
                    state_next = ST_LOWPWR;
                else if (wake_throttle_reg && !throttle_neutral_i)
                    state_next = ST_NORMAL;
            end
            ST_LOWPWR:
            begin
                if (lp_done || battery_flat_i)
                    state_next = ST_DOWN;
                else if (key_rise)
                    state_next = ST_NORMAL;
            end
            default:
                state_next = ST_DOWN;
        endcase
    end

    // State and key sample
    always @(posedge sys_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            state_reg    <= ST_DOWN;
            key_prev_reg <= 1'b0;
        end
        else
        begin
            state_reg    <= state_next;
            key_prev_reg <= key_on_i;
        end
    end

    // Five-second flash phase while sleeping
    always @(posedge sys_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            flash_reg <= 3'h0;
        else if (state_next != ST_SLEEP || state_chg)
            flash_reg <= 3'h0;
        else if (sec_tick)
            flash_reg <= (flash_reg == FLASH_LAST) ? 3'h0 : flash_reg + 3'h1;
    end

    // Registered mode outputs
    always @(posedge sys_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            power_state_o    <= ST_DOWN;
            drive_enable_o   <= 1'b0;
            monitor_enable_o <= 1'b0;
            status_frame_o   <= 1'b0;
            sleep_led_o      <= 1'b0;
        end
        else
        begin
            power_state_o    <= state_reg;
            // Only normal mode drives; sleep ignores throttle
            drive_enable_o   <= (state_reg == ST_NORMAL);
            // Inputs stay powered in every powered state
            monitor_enable_o <= (state_reg != ST_DOWN);
            case (state_reg)
                ST_NORMAL: status_frame_o <= sec_tick;
                ST_SLEEP:  status_frame_o <= sec_tick;
                ST_LOWPWR: status_frame_o <= lpstat_due;
                default:   status_frame_o <= 1'b0;
            endcase
            // Lit for the first second of each five-second period
            sleep_led_o      <= (state_reg == ST_SLEEP) && (flash_reg == 3'h0);
        end
    end

    // Wishbone request, answered one cycle later
    assign wb_req   = wb_cyc_i & wb_stb_i;
    assign wb_write = wb_req & wb_we_i & wb_ack_o;

    // Duration write limited to the supported range
    always @*
    begin
        days_wr = wb_dat_i[`CTRL_DAYS_LSB +: `CTRL_DAYS_W];
        if (days_wr > DAYS_MAX)
            days_wr = DAYS_MAX;
    end

    // Control register, written on the acknowledged edge
    always @(posedge sys_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            sleep_min_reg     <= `CTRL_MIN_RST;
            wake_throttle_reg <= `CTRL_WAKE_RST;
            lp_days_reg       <= `CTRL_DAYS_RST;
        end
        else if (wb_write && wb_adr_i == `REG_CTRL)
        begin
            if (wb_sel_i[0])
                sleep_min_reg     <= wb_dat_i[`CTRL_MIN_LSB +: `CTRL_MIN_W];
            if (wb_sel_i[1])
                wake_throttle_reg <= wb_dat_i[`CTRL_WAKE_BIT];
            if (wb_sel_i[2])
                lp_days_reg       <= days_wr;
        end
    end

    // Acknowledge and read data
    always @(posedge sys_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end
        else
        begin
            wb_ack_o <= wb_req & ~wb_ack_o;
            wb_dat_o <= 32'h00000000;
            if (wb_req && !wb_ack_o && !wb_we_i)
            begin
                case (wb_adr_i)
                    `REG_CTRL:
                    begin
                        wb_dat_o[`CTRL_MIN_LSB +: `CTRL_MIN_W]   <= sleep_min_reg;
                        wb_dat_o[`CTRL_WAKE_BIT]                 <= wake_throttle_reg;
                        wb_dat_o[`CTRL_DAYS_LSB +: `CTRL_DAYS_W] <= lp_days_reg;
                    end
                    `REG_STATUS:
                    begin
                        wb_dat_o[`STAT_STATE_LSB +: 2]  <= state_reg;
                        wb_dat_o[`STAT_DRIVE_BIT]       <= drive_enable_o;
                        wb_dat_o[`STAT_KEY_BIT]         <= key_prev_reg;
                        wb_dat_o[`STAT_LED_BIT]         <= sleep_led_o;
                        wb_dat_o[`STAT_INACT_LSB +: 16] <= inact_cnt;
                    end
                    default:
                        wb_dat_o <= 32'h00000000;
                endcase
            end
        end
    end
endmodule // power_mode_fsm
`default_nettype wire

// ---- power_mode_fsm_props.sv ----
// Port checker for the power-mode sequencer
`default_nettype none
module power_mode_fsm_props #(
    parameter int SEC_CYCLES  = 100000000,
    parameter int LP_STATUS_S = 43200
) (
    // Clock, reset and bus
    input  wire logic       sys_clk_i,
    input  wire logic       arst_n_i,
    input  wire logic       wb_ack_o,
    // Sensing
    input  wire logic       key_on_i,
    input  wire logic       throttle_fault_i,
    input  wire logic       battery_flat_i,
    input  wire logic       battery_charging_i,
    // Mode outputs
    input  wire logic [1:0] power_state_o,
    input  wire logic       drive_enable_o,
    input  wire logic       monitor_enable_o,
    input  wire logic       status_frame_o,
    input  wire logic       sleep_led_o
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int LED_GAP = 5 * SEC_CYCLES - 1;
    localparam longint LP_GAP = longint'(LP_STATUS_S - 2) * SEC_CYCLES;
    localparam int FRM_MAX = 2 * SEC_CYCLES + 2;
    logic [31:0] led_cnt_reg;
    logic [31:0] frm_gap_reg;
    logic [47:0] lp_gap_reg;
    logic [1:0]  led_rise_reg;
    logic        led_q_reg;
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!arst_n_i);
    // Cycles since the last indicator rise, any frame and any low-power frame
    always @(posedge sys_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            led_cnt_reg  <= 32'h0;
            frm_gap_reg  <= 32'h0;
            lp_gap_reg   <= 48'h0;
            led_rise_reg <= 2'h0;
            led_q_reg    <= 1'b0;
        end
        else
        begin
            led_q_reg   <= sleep_led_o;
            led_cnt_reg <= (sleep_led_o && !led_q_reg) ? 32'h0 : led_cnt_reg + 32'h1;
            if (power_state_o != 2'h2)
                led_rise_reg <= 2'h0;
            else if (sleep_led_o && !led_q_reg && led_rise_reg != 2'h3)
                led_rise_reg <= led_rise_reg + 2'h1;
            frm_gap_reg <= (status_frame_o || !(^power_state_o)) ? 32'h0 : frm_gap_reg + 32'h1;
            lp_gap_reg  <= (status_frame_o || power_state_o != 2'h3) ? 48'h0 : lp_gap_reg + 48'h1;
        end
    end
    AST_DRIVE_NORMAL: assert property (drive_enable_o == (power_state_o == 2'h1))
        else $error("drive enable outside normal mode");
    AST_MONITOR_AWAKE: assert property (monitor_enable_o == (power_state_o != 2'h0))
        else $error("monitoring does not follow power state");
    AST_DOWN_SILENT: assert property (power_state_o == 2'h0 |-> !status_frame_o)
        else $error("status frame while powered down");
    AST_DOWN_EXIT: assert property (power_state_o == 2'h0 ##1 power_state_o != 2'h0
        |-> power_state_o == 2'h1) else $error("powered down left to a mode other than normal");
    AST_KEY_ON_UP: assert property (power_state_o == 2'h0 && $rose(key_on_i)
        |-> ##2 power_state_o == 2'h1) else $error("key on did not power up");
    AST_KEY_OFF_NORMAL: assert property (power_state_o == 2'h1 && $fell(key_on_i)
        |-> ##2 power_state_o inside {2'h0, 2'h3}) else $error("key off left normal wrongly");
    AST_SLEEP_EXIT: assert property ((throttle_fault_i || battery_flat_i ||
        battery_charging_i || !key_on_i) ##1 power_state_o == 2'h2 |=> power_state_o inside
        {2'h0, 2'h3}) else $error("sleep not left for low power");
    AST_LP_FLAT: assert property (battery_flat_i ##1 power_state_o == 2'h3
        |=> power_state_o == 2'h0) else $error("flat battery kept low power");
    AST_LED_PERIOD: assert property ($rose(sleep_led_o) && led_rise_reg >= 2'h2
        |-> led_cnt_reg == LED_GAP) else $error("sleep indicator period wrong");
    AST_FRAME_DUE: assert property (frm_gap_reg < FRM_MAX)
        else $error("status frame overdue in normal or sleep");
    AST_FRAME_SPACING: assert property (status_frame_o |=> !status_frame_o [*8])
        else $error("status frames too close");
    AST_LP_RARE: assert property (status_frame_o && power_state_o == 2'h3 && lp_gap_reg > 2
        |-> lp_gap_reg >= LP_GAP) else $error("low power frame too early");
    AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("bus acknowledge longer than one cycle");
endmodule // power_mode_fsm_props
bind power_mode_fsm power_mode_fsm_props #(.SEC_CYCLES(SEC_CYCLES), .LP_STATUS_S(LP_STATUS_S))
    u_props (.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .wb_ack_o(wb_ack_o),
    .key_on_i(key_on_i), .throttle_fault_i(throttle_fault_i), .battery_flat_i(battery_flat_i),
    .battery_charging_i(battery_charging_i), .power_state_o(power_state_o),
    .drive_enable_o(drive_enable_o), .monitor_enable_o(monitor_enable_o),
    .status_frame_o(status_frame_o), .sleep_led_o(sleep_led_o));
`default_nettype wire

// ---- power_mode_map.vh ----
// Constants for the controller power-mode sequencer
`ifndef POWER_MODE_MAP_VH
`define POWER_MODE_MAP_VH

// Clock and time base
`define CLK_PERIOD_NS   10
`define SEC_NS          1000000000
`define SEC_CYCLES      (`SEC_NS / `CLK_PERIOD_NS)
`define SEC_CNT_W       27

// Times in seconds, hours and days
`define MIN_S           16'h003c
`define HOUR_S          3600
`define DAY_S           86400
`define SLEEP_MAX_H     6
`define SLEEP_MAX_S     (`SLEEP_MAX_H * `HOUR_S)
`define LP_STATUS_H     12
`define LP_STATUS_S     (`LP_STATUS_H * `HOUR_S)
`define FLASH_PERIOD_S  3'h5
`define NORM_STATUS_S   1
`define LP_DAYS_MAX     7'h5a

// Power states
`define ST_DOWN         2'h0
`define ST_NORMAL       2'h1
`define ST_SLEEP        2'h2
`define ST_LOWPWR       2'h3

// Register byte offsets
`define REG_CTRL        8'h00
`define REG_STATUS      8'h04

// Control register fields and reset values
`define CTRL_MIN_LSB    0
`define CTRL_MIN_W      8
`define CTRL_WAKE_BIT   8
`define CTRL_DAYS_LSB   16
`define CTRL_DAYS_W     7
`define CTRL_MIN_RST    8'h00
`define CTRL_WAKE_RST   1'b0
`define CTRL_DAYS_RST   7'h00

// Status register fields
`define STAT_STATE_LSB  0
`define STAT_DRIVE_BIT  2
`define STAT_KEY_BIT    3
`define STAT_LED_BIT    4
`define STAT_INACT_LSB  16

`endif

// ---- sec_counter.v ----
// Saturating seconds counter with synchronous clear
`default_nettype none
module sec_counter #(
    parameter W = 16
) (
    // Clock and reset
    input  wire          sys_clk_i,
    input  wire          arst_n_i,
    // Control
    input  wire          clear_i,
    input  wire          tick_i,
    // Count
    output reg  [W-1:0]  count_o
);
    // Clear wins over tick; the count holds at its top value
    always @(posedge sys_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            count_o <= {W{1'b0}};
        else if (clear_i)
            count_o <= {W{1'b0}};
        else if (tick_i && (count_o != {W{1'b1}}))
            count_o <= count_o + 1'b1;
    end
endmodule // sec_counter
`default_nettype wire

// ---- sec_tick_gen.v ----
// One-second tick generator from the system clock
`default_nettype none
module sec_tick_gen #(
    parameter CYCLES = 100000000,
    parameter CW     = 27
) (
    // Clock and reset
    input  wire          sys_clk_i,
    input  wire          arst_n_i,
    // Tick
    output reg           tick_o
);
    localparam [CW-1:0] LAST = CYCLES[CW-1:0] - 1'b1;

    reg [CW-1:0] cnt_reg;

    // Free-running divider, one pulse per wrap
    always @(posedge sys_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            cnt_reg <= {CW{1'b0}};
            tick_o  <= 1'b0;
        end
        else if (cnt_reg == LAST)
        begin
            cnt_reg <= {CW{1'b0}};
            tick_o  <= 1'b1;
        end
        else
        begin
            cnt_reg <= cnt_reg + 1'b1;
            tick_o  <= 1'b0;
        end
    end
endmodule // sec_tick_gen
`default_nettype wire

// ---- sensor_model.sv ----
// Behavioural key switch, throttle and battery sensors
`default_nettype none
module sensor_model (
    // Clock and command: key, deflect, fault, flat, charging
    input  wire logic       sys_clk_i,
    input  wire logic [4:0] cmd_i,
    // Sensed levels
    output var  logic       key_on_o,
    output var  logic       throttle_neutral_o,
    output var  logic       throttle_fault_o,
    output var  logic       battery_flat_o,
    output var  logic       battery_charging_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // Sensors start idle: key off, throttle at rest
    initial
    begin
        {battery_charging_o, battery_flat_o, throttle_fault_o, key_on_o} = 4'h0;
        throttle_neutral_o = 1'b1;
    end
    // Each level follows its command one clock later, like a sampled switch
    always @(posedge sys_clk_i)
    begin
        key_on_o           <= cmd_i[0];
        throttle_neutral_o <= !cmd_i[1];
        throttle_fault_o   <= cmd_i[2];
        battery_flat_o     <= cmd_i[3];
        battery_charging_o <= cmd_i[4];
    end
endmodule // sensor_model
`default_nettype wire

// ---- test_controller_power_mode_fsm.sv ----
// Self-checking bench for the power-mode sequencer
`include "power_mode_map.vh"
`default_nettype none
module test_controller_power_mode_fsm;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [31:0] ctrl;
        logic [4:0]  a1;
        logic [1:0]  e1;
        logic [4:0]  a2;
        logic [1:0]  e2;
    } row_t;
    row_t        rows [9];
    logic        sys_clk_i;
    logic        arst_n_i;
    logic        wb_cyc;
    logic        wb_stb;
    logic        wb_we;
    logic [7:0]  wb_adr;
    logic [31:0] wb_wdat;
    logic [31:0] wb_rdat;
    logic [31:0] rd;
    logic        wb_ack;
    logic [4:0]  cmd;
    logic        key_on, neutral, fault, flat, chg;
    logic [1:0]  power_state;
    logic        drive_en, mon_en, frame, led;
    int          failures, checks_done, i, n_hi;
    // Sensors and design under test
    sensor_model u_sense (.sys_clk_i(sys_clk_i), .cmd_i(cmd), .key_on_o(key_on),
        .throttle_neutral_o(neutral), .throttle_fault_o(fault), .battery_flat_o(flat),
        .battery_charging_o(chg));
    power_mode_fsm #(.SEC_CYCLES(10), .DAY_S(20), .SLEEP_MAX_S(30), .LP_STATUS_S(8)) dut (
        .sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
        .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hf), .wb_dat_i(wb_wdat),
        .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .key_on_i(key_on), .throttle_neutral_i(neutral),
        .throttle_fault_i(fault), .battery_flat_i(flat), .battery_charging_i(chg),
        .power_state_o(power_state), .drive_enable_o(drive_en), .monitor_enable_o(mon_en),
        .status_frame_o(frame), .sleep_led_o(led));
    // 100 MHz clock
    initial
    begin
        sys_clk_i = 1'b0;
        forever #5 sys_clk_i = ~sys_clk_i;
    end
    task automatic expect_eq(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks_done++;
        if (got !== exp)
        begin
            failures++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    // One classic Wishbone cycle, held until acknowledge
    task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] wdat);
        int n;
        n = 0;
        @(posedge sys_clk_i);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= adr;
        wb_wdat <= wdat;
        do
        begin
            @(posedge sys_clk_i);
            n++;
        end while (wb_ack !== 1'b1 && n < 50);
        rd = wb_rdat;
        expect_eq(wb_ack, 1'b1, "bus acknowledge");
        if (wb_ack !== 1'b1)
            final_report;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
    endtask
    task automatic act(input logic [4:0] v);
        @(posedge sys_clk_i);
        cmd <= v;
    endtask
    task automatic wait_state(input logic [1:0] exp, input int bound);
        int n;
        n = 0;
        while (power_state !== exp && n < bound)
        begin
            @(posedge sys_clk_i);
            n++;
        end
        expect_eq(power_state, exp, "power state");
        if (power_state !== exp)
            final_report;
    endtask
    // Reset with all sensors idle, then key on and program the control word
    task automatic start_normal(input logic [31:0] ctrl);
        @(posedge sys_clk_i);
        arst_n_i <= 1'b0;
        cmd <= 5'h00;
        repeat (5) @(posedge sys_clk_i);
        expect_eq({power_state, drive_en, mon_en, frame, led, wb_ack}, 32'h0, "reset outputs");
        arst_n_i <= 1'b1;
        wb_xfer(1'b0, `REG_CTRL, 32'h0);
        expect_eq(rd, 32'h0, "control reset value");
        act(5'h01);
        wait_state(`ST_NORMAL, 10);
        wb_xfer(1'b1, `REG_CTRL, ctrl);
    endtask
    task automatic final_report;
        $display("Checks done: %0d, failures: %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // Mode-change table: control word, first event, mode, second event, mode
    initial
    begin
        rows[0] = '{32'h0, 5'h00, `ST_DOWN, 5'h01, `ST_NORMAL};
        rows[1] = '{32'h10000, 5'h00, `ST_LOWPWR, 5'h01, `ST_NORMAL};
        rows[2] = '{32'h10001, 5'h01, `ST_SLEEP, 5'h05, `ST_LOWPWR};
        rows[3] = '{32'h10001, 5'h01, `ST_SLEEP, 5'h11, `ST_LOWPWR};
        rows[4] = '{32'h10101, 5'h01, `ST_SLEEP, 5'h03, `ST_NORMAL};
        rows[5] = '{32'h10000, 5'h00, `ST_LOWPWR, 5'h00, `ST_DOWN};
        rows[6] = '{32'h10000, 5'h00, `ST_LOWPWR, 5'h08, `ST_DOWN};
        rows[7] = '{32'h10001, 5'h01, `ST_SLEEP, 5'h00, `ST_LOWPWR};
        rows[8] = '{32'h00001, 5'h01, `ST_SLEEP, 5'h09, `ST_DOWN};
        arst_n_i = 1'b0;
        wb_cyc = 1'b0;
        wb_stb = 1'b0;
        wb_we = 1'b0;
        wb_adr = 8'h00;
        wb_wdat = 32'h0;
        cmd = 5'h00;
        failures = 0;
        checks_done = 0;
        for (i = 0; i < 9; i++)
        begin
            start_normal(rows[i].ctrl);
            act(rows[i].a1);
            wait_state(rows[i].e1, 1000);
            act(rows[i].a2);
            wait_state(rows[i].e2, 1000);
        end
        // Day count clamps at its limit; status and an unmapped place read back
        start_normal(32'h007f_0000);
        wb_xfer(1'b0, `REG_CTRL, 32'h0);
        expect_eq(rd, 32'h005a_0000, "low power days limit");
        wb_xfer(1'b0, `REG_STATUS, 32'h0);
        expect_eq(rd[4:0], 5'h0d, "status in normal");
        wb_xfer(1'b0, 8'h08, 32'h0);
        expect_eq(rd, 32'h0, "unmapped read");
        // One status frame per second while awake
        n_hi = 0;
        repeat (100)
        begin
            @(posedge sys_clk_i);
            if (frame === 1'b1)
                n_hi++;
        end
        expect_eq(n_hi, 10, "status frames in ten seconds");
        // A short deflection restarts the sleep timer; sleep ignores the throttle
        start_normal(32'h0001_0001);
        repeat (400) @(posedge sys_clk_i);
        act(5'h03);
        act(5'h01);
        repeat (400) @(posedge sys_clk_i);
        expect_eq(power_state, `ST_NORMAL, "inactivity restart");
        wait_state(`ST_SLEEP, 400);
        act(5'h03);
        repeat (30) @(posedge sys_clk_i);
        expect_eq({power_state, drive_en, mon_en}, {`ST_SLEEP, 2'b01}, "sleep drive");
        // Indicator lit one second in each five-second period
        n_hi = 0;
        repeat (50)
        begin
            @(posedge sys_clk_i);
            if (led === 1'b1)
                n_hi++;
        end
        expect_eq(n_hi, 10, "sleep indicator lit time");
        act(5'h01);
        wait_state(`ST_LOWPWR, 400);
        wait_state(`ST_DOWN, 400);
        final_report;
    end
endmodule // test_controller_power_mode_fsm
`default_nettype wire
